// File: sim/clk_lock_model.sv
// Far-side model: transmit and receive clock lock after reset exit.
// Assumes lock times counted in reference clock cycles.
`timescale 1ns/1ns
module clk_lock_model #(
   parameter LOCK = 30
) (
   input  wire mclk_i,             // Clock
   input  wire run_i,              // Sequencer running
   output reg  txclk_ok_o = 1'b0,  // TX clock valid
   output reg  rxclk_ok_o = 1'b0   // RX clock valid
);
   integer cnt = 0;
   // --------------------
   // Lock counter
   // --------------------
   // Any reset or power-down loses lock; RX locks later than TX
   always @(posedge mclk_i) begin
      cnt = run_i ? cnt + 1 : 0;
      txclk_ok_o <= (cnt > LOCK);
      rxclk_ok_o <= (cnt > LOCK + 3);
   end
endmodule

// File: sim/rst_seq_checker_asserts.sv
// Port checks for the reset and power-down sequencer.
// Assumes one reference clock and an async active-high reset.
`timescale 1ns/1ns
module rst_seq_checker (
   input wire       mclk_i,                     // Clock
   input wire       sys_rst_i,                  // Power-on
   input wire       hardware_reset_input_low_i, // Pin
   input wire       speed100_i,                 // 100M
   input wire       txclk_ok_i,                 // TX valid
   input wire       rxclk_ok_i,                 // RX valid
   input wire       in_reset_o,                 // Reset
   input wire       reset_done_o,               // Done
   input wire       power_down_o,               // Power-down
   input wire       mac_out_en_o,               // MAC out
   input wire       mac_in_en_o,                // MAC in
   input wire       line_tx_oe_o,               // Line drive
   input wire       en100_o,                    // 100M on
   input wire       en10_o,                     // 10M on
   input wire       soft_rst_bit_o,             // Soft bit
   input wire       pwr_down_bit_o,             // Power bit
   input wire [1:0] save_bits_o                 // Save bits
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff sys_rst_i;
   // --------------------
   // Soft reset steps and port checks
   // --------------------
   sequence soft_go;
      $rose(soft_rst_bit_o);
   endsequence
   sequence rst_two;
      ##1 in_reset_o [*2] ##1 !in_reset_o;
   endsequence
   // Settings held long enough for the enables to follow them
   sequence run_steady;
      (reset_done_o && !power_down_o && $stable(save_bits_o)
         && $stable(speed100_i)) [*3];
   endsequence
   pin_pd_a: assert property (
      (!hardware_reset_input_low_i) [*6] |-> power_down_o)
      else $error("no power-down with pin low");
   bit_pd_a: assert property (
      pwr_down_bit_o |-> ##[0:2] power_down_o)
      else $error("no power-down with bit set");
   pd_gate_a: assert property (
      power_down_o [*2] |-> !mac_out_en_o && !line_tx_oe_o)
      else $error("outputs live in power-down");
   rst_gate_a: assert property (
      in_reset_o [*2] |-> !mac_in_en_o && !mac_out_en_o && !line_tx_oe_o)
      else $error("interface live in reset");
   hw_soft_a: assert property (
      in_reset_o && power_down_o |-> !soft_rst_bit_o)
      else $error("soft bit set by hard reset");
   soft_pd_a: assert property (
      soft_rst_bit_o && in_reset_o |-> !power_down_o)
      else $error("soft reset powered down");
   soft_len_a: assert property (
      soft_go |-> rst_two)
      else $error("soft reset not two cycles");
   soft_clr_a: assert property (
      soft_go |-> ##[1:12] !soft_rst_bit_o)
      else $error("soft bit did not clear");
   done_clk_a: assert property (
      $rose(reset_done_o) |-> $past(txclk_ok_i) && $past(rxclk_ok_i))
      else $error("done before clocks valid");
   save_en_a: assert property (
      run_steady |-> en100_o == !(save_bits_o[0] && !speed100_i)
         && en10_o == !(save_bits_o[1] && speed100_i))
      else $error("module enable wrong");
endmodule
bind phy_reset_power_sequencer rst_seq_checker u_chk (
   .mclk_i, .sys_rst_i, .hardware_reset_input_low_i, .speed100_i,
   .txclk_ok_i, .rxclk_ok_i, .in_reset_o, .reset_done_o, .power_down_o,
   .mac_out_en_o, .mac_in_en_o, .line_tx_oe_o, .en100_o, .en10_o,
   .soft_rst_bit_o, .pwr_down_bit_o, .save_bits_o
);

// File: sim/testbench.sv
// Self-checking bench for the reset and power-down sequencer.
// Assumes the lock model supplies the clock-valid inputs.
`timescale 1ns/1ns
module testbench;
   localparam POR  = 40;
   localparam EXIT = 16;
   localparam LOCK = 30;
   reg        mclk_i = 1'b0, sys_rst_i = 1'b1, rst_pin_n = 1'b0;
   reg  [4:0] port_addr_i = 5'h0;
   reg        soft_wr = 1'b0, pd_wr = 1'b0, pd_val = 1'b0, save_wr = 1'b0;
   reg  [1:0] save_val = 2'h0;
   reg        speed100 = 1'b0, soft_seen = 1'b0;
   reg  [2:0] latch_set = 3'h0;
   wire       tx_ok, rx_ok, in_rst, mgmt_rdy, done, pd, mac_out, mac_in;
   wire       line_oe, en100, en10, soft_bit, pd_bit;
   wire [1:0] save_bits;
   wire [4:0] addr;
   wire [2:0] latch;
   integer    err_total = 0, cmp_count = 0, n, i, exp_addr;
   phy_reset_power_sequencer #(.POR_CYC(POR)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .hardware_reset_input_low_i(rst_pin_n), .port_addr_i(port_addr_i),
      .soft_rst_wr_i(soft_wr), .pwr_down_wr_i(pd_wr), .pwr_down_val_i(pd_val),
      .save_wr_i(save_wr), .save_val_i(save_val), .speed100_i(speed100),
      .txclk_ok_i(tx_ok), .rxclk_ok_i(rx_ok), .latch_set_i(latch_set),
      .in_reset_o(in_rst), .mgmt_ready_o(mgmt_rdy), .reset_done_o(done),
      .power_down_o(pd), .mac_out_en_o(mac_out), .mac_in_en_o(mac_in),
      .line_tx_oe_o(line_oe), .en100_o(en100), .en10_o(en10),
      .soft_rst_bit_o(soft_bit), .pwr_down_bit_o(pd_bit),
      .save_bits_o(save_bits), .addr_field_o(addr),
      .latching_low_status_bit_o(latch[0]),
      .latching_high_status_bit_o(latch[1]),
      .latching_maximum_status_bit_o(latch[2]));
   clk_lock_model #(.LOCK(LOCK)) u_lock (.mclk_i(mclk_i),
      .run_i(mgmt_rdy && !in_rst && !pd), .txclk_ok_o(tx_ok),
      .rxclk_ok_o(rx_ok));
   // --------------------
   // Clock and helpers
   // --------------------
   always #5 mclk_i = ~mclk_i;
   // The soft bit is brief, so catch it whenever it shows
   always @(posedge mclk_i)
      if (soft_bit === 1'b1) soft_seen <= 1'b1;
   task cyc(input integer k);
      begin
         repeat (k) @(posedge mclk_i);
         #1;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_in(input integer got, input integer lo, input integer hi);
      begin
         cmp_count = cmp_count + 1;
         if (got < lo || got > hi) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
         end
      end
   endtask
   task wait_hi(input integer sel, output integer k);
      begin
         k = 0;
         #1;
         while (k < 500 && (sel ? done : mgmt_rdy) !== 1'b1) begin
            @(posedge mclk_i);
            #1;
            k = k + 1;
         end
      end
   endtask
   // One-cycle write strobes, taken at the second edge
   task wr(input integer k, input [1:0] v);
      begin
         @(posedge mclk_i);
         soft_wr <= (k == 0);
         pd_wr <= (k == 1);
         save_wr <= (k == 2);
         pd_val <= v[0];
         save_val <= v;
         @(posedge mclk_i);
         soft_wr <= 1'b0;
         pd_wr <= 1'b0;
         save_wr <= 1'b0;
      end
   endtask
   task finish_test;
      begin
         $display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      repeat (3000) @(posedge mclk_i);
      err_total = err_total + 1;
      finish_test;
   end
   // --------------------
   // Main sequence
   // --------------------
   initial begin
      n = $urandom(32'he2c5b9fd);
      repeat (6) @(posedge mclk_i);
      exp_addr = $urandom % 32;
      port_addr_i <= exp_addr[4:0];
      sys_rst_i <= 1'b0;
      // Pin held low through part of the power-on hold
      repeat (8) @(posedge mclk_i);
      rst_pin_n <= 1'b1;
      wait_hi(0, n);
      // Hold is about POR cycles, then exit within sixteen clocks
      chk_in(n + 8, POR + 1, POR + 18);
      chk({addr, done}, {exp_addr[4:0], 1'b0});
      wait_hi(1, n);
      chk_in(n, LOCK, LOCK + 12);
      chk({mac_out, mac_in, line_oe}, 3'h7);
      chk({tx_ok, rx_ok, mac_out}, 3'h7);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge mclk_i);
         speed100 <= i[2];
         wr(2, i[1:0]);
         cyc(4);
         chk({save_bits, en100, en10}, {i[1:0], !(i[0] && !i[2]),
            !(i[1] && i[2])});
      end
      // Events keep arriving while powered down
      @(posedge mclk_i);
      latch_set <= 3'h7;
      cyc(2);
      chk(latch, 3'h7);
      wr(1, 2'h1);
      cyc(4);
      chk({pd, pd_bit, mac_out, line_oe, latch}, 7'h60);
      chk({save_bits, addr}, {2'h3, exp_addr[4:0]});
      @(posedge mclk_i);
      latch_set <= 3'h0;
      port_addr_i <= ~exp_addr[4:0];
      wr(1, 2'h0);
      cyc(LOCK + 40);
      chk({pd, done}, 2'h1);
      wr(0, 2'h0);
      cyc(LOCK + 40);
      chk({soft_seen, soft_bit, pd_bit, save_bits}, 5'h10);
      chk({addr, done}, {exp_addr[4:0], 1'b1});
      // Save bits set so the hard reset has defaults to restore
      wr(2, 2'h3);
      cyc(2);
      chk(save_bits, 2'h3);
      // Hard reset held eight cycles, straps now moved
      exp_addr = exp_addr ^ 31;
      @(posedge mclk_i);
      rst_pin_n <= 1'b0;
      repeat (7) @(posedge mclk_i);
      #1;
      chk({pd, in_rst, mac_out, mac_in, line_oe, soft_bit},
         6'h30);
      @(posedge mclk_i);
      rst_pin_n <= 1'b1;
      wait_hi(0, n);
      chk_in(n, 1, EXIT);
      chk({addr, save_bits}, {exp_addr[4:0], 2'h0});
      wait_hi(1, n);
      chk(done, 1'b1);
      finish_test;
   end
endmodule

// File: verilog/phy_reset_power_sequencer.v
// Reset, power-down and power-saving sequencer of a 10/100 transceiver.
// Assumes ref clock of 100 MHz, management writes as one-cycle pulses.
//
// Notes on behaviour
// [R01] Exit steps done within sixteen reference clocks
// [R02] Management ready once exit steps finish
// [R03] Reset completes when MII clocks valid
// [R04] MAC waits for valid MII clocks; code skips the wait when the power-down bit is cleared
// [R05] Soft reset bit never set by hard
// [R06] Power-on reset holds about 20 us
// [R07] Power-on exit matches hardware reset exit
// [R08] Hardware reset pin ignored during power-on
// [R09] Soft reset write holds reset two clocks
// [R10] Soft reset does not power down
// [R11] Reset end loads defaults, clears bit
// [R12] Soft reset keeps management address
// [R13] Power-down while pin low or bit set
// [R14] Power-down gates MAC outputs, line tristate
// [R15] Bit power-down clears only latching bits
// [R16] Reset power-down restores all defaults
// [R17] 100M save bit disables 100M at 10M
// [R18] 10M save bit disables 10M at 100M
// [R19] Reset entry isolates, drives low, inits
// [R20] Hard reset exit latches management address
// [R21] External reset pulse at least five clocks
// [R22] Synchronise pin, count in reference clocks
// [R23] Complete status after both clocks valid
`timescale 1ns/1ns
`include "rst_seq_map.vh"
module phy_reset_power_sequencer #(
   parameter POR_CYC = (`POR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter CW      = 16
) (
   input  wire       mclk_i,                   // Reference clock
   input  wire       sys_rst_i,                // Power-on, active high
   input  wire       hardware_reset_input_low_i, // Reset pin, active low
   input  wire [4:0] port_addr_i,              // Address straps
   input  wire       soft_rst_wr_i,            // Write one to soft reset
   input  wire       pwr_down_wr_i,            // Write power-down bit
   input  wire       pwr_down_val_i,           // Value written
   input  wire       save_wr_i,                // Write save bits
   input  wire [1:0] save_val_i,               // {10M, 100M} save
   input  wire       speed100_i,               // Running at 100M
   input  wire       txclk_ok_i,               // TX PLL locked
   input  wire       rxclk_ok_i,               // RX PLL locked
   input  wire [2:0] latch_set_i,              // LL, LH, LATCHING_MAXIMUM_STATUS_BIT events
   output reg        in_reset_o,               // Internal reset
   output reg        mgmt_ready_o,             // Management usable
   output reg        reset_done_o,             // Reset cycle complete
   output reg        power_down_o,             // Power-down state
   output reg        mac_out_en_o,             // MAC outputs enabled
   output reg        mac_in_en_o,              // MAC inputs admitted
   output reg        line_tx_oe_o,             // Line transmit enable
   output reg        en100_o,                  // 100M modules on
   output reg        en10_o,                   // 10M modules on
   output reg        soft_rst_bit_o,           // Control bit 15
   output reg        pwr_down_bit_o,           // Control bit 11
   output reg  [1:0] save_bits_o,              // Ext control 2 bits
   output reg  [4:0] addr_field_o,             // Ext control address
   output reg        latching_low_status_bit_o,     // Latch-low status
   output reg        latching_high_status_bit_o,    // Latch-high status
   output reg        latching_maximum_status_bit_o  // Latch-max status
);
   // ---------------------------------------------------------------
   // Constants and state
   // ---------------------------------------------------------------
   // A timed state lasts its load value plus two clocks; the exit load
   // also leaves room for the two sync stages and the ready flop
   localparam [CW-1:0] EXIT_CYC = `EXIT_STEPS_REFCLK - 5;
   localparam [CW-1:0] POR_LD   = POR_CYC - 1;
   localparam [CW-1:0] SOFT_LD  = `SOFT_RST_REFCLK - 2;
   localparam [2:0] S_POR  = 3'h0;
   localparam [2:0] S_HW   = 3'h1;
   localparam [2:0] S_EXIT = 3'h2;
   localparam [2:0] S_LOCK = 3'h3;
   localparam [2:0] S_RUN  = 3'h4;
   localparam [2:0] S_SOFT = 3'h5;

   reg [2:0]    state;
   reg [2:0]    next_state;
   reg          pin_meta;
   reg          pin_sync;
   reg          soft_exit;
   reg          por_kick;
   reg          cnt_load;
   reg [CW-1:0] cnt_val;
   wire         cnt_done;

   // Loaded each time a timed phase starts
   sync_cnt #(.W(CW)) u_cnt (
      .clk_i   (mclk_i),
      .rst_i   (sys_rst_i),
      .load_i  (cnt_load),
      .value_i (cnt_val),
      .done_o  (cnt_done)
   );

   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   // Two stages; pin is asynchronous so only pin_sync is examined
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= hardware_reset_input_low_i; // [R22]
         pin_sync <= pin_meta;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer next state
   // ---------------------------------------------------------------
   // The pin is honoured in every state except power-on hold
   always @* begin
      next_state = state;
      cnt_load   = 1'b0;
      cnt_val    = EXIT_CYC;
      case (state)
         S_POR: begin
            if (cnt_done) begin // [R06] [R08]
               next_state = S_EXIT; // [R07]
               cnt_load   = 1'b1;
            end
         end
         S_HW: begin
            if (pin_sync) begin
               next_state = S_EXIT;
               cnt_load   = 1'b1; // [R22]
            end
         end
         S_EXIT: begin
            if (!pin_sync)
               next_state = S_HW;
            else if (cnt_done)
               next_state = S_LOCK; // [R01]
         end
         S_LOCK: begin
            if (!pin_sync)
               next_state = S_HW;
            else if (txclk_ok_i && rxclk_ok_i)
               next_state = S_RUN; // [R03] [R23]
         end
         S_RUN: begin
            if (!pin_sync)
               next_state = S_HW;
            else if (soft_rst_wr_i) begin
               next_state = S_SOFT; // [R09]
               cnt_load   = 1'b1;
               cnt_val    = SOFT_LD;
            end
         end
         S_SOFT: begin
            if (!pin_sync)
               next_state = S_HW;
            else if (cnt_done)
               next_state = S_LOCK;
         end
         default: next_state = S_HW;
      endcase
      // Power-on hold is timed from the first edge after release
      if (por_kick) begin
         cnt_load = 1'b1;
         cnt_val  = POR_LD; // [R06]
      end
   end

   // ---------------------------------------------------------------
   // State register and power-on count start
   // ---------------------------------------------------------------
   // The power-on hold counter is kicked on the first edge after release
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state    <= S_POR;
         por_kick <= 1'b1;
      end else begin
         por_kick <= 1'b0;
         if (por_kick)
            state <= S_POR;
         else
            state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Management register bits
   // ---------------------------------------------------------------
   // Soft reset state also reloads defaults but keeps the address
   wire hard_rst = (state == S_POR) || (state == S_HW);
   wire any_rst  = hard_rst || (state == S_SOFT) || por_kick;
   wire leave_hw = (state == S_EXIT) && (next_state == S_LOCK);
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         soft_rst_bit_o <= 1'b0;
         pwr_down_bit_o <= `PWR_DOWN_RST;
         save_bits_o    <= {`SAVE_RST, `SAVE_RST};
         addr_field_o   <= 5'h00;
         soft_exit      <= 1'b0;
         latching_low_status_bit_o     <= 1'b0;
         latching_high_status_bit_o    <= 1'b0;
         latching_maximum_status_bit_o <= 1'b0;
      end else begin
         soft_exit <= (state == S_SOFT);
         if (any_rst) begin
            // Soft bit only rises by write, hard resets never set it
            soft_rst_bit_o <= (state == S_SOFT); // [R05] [R11]
            pwr_down_bit_o <= `PWR_DOWN_RST; // [R16]
            save_bits_o    <= {`SAVE_RST, `SAVE_RST};
            {latching_maximum_status_bit_o, latching_high_status_bit_o,
             latching_low_status_bit_o} <= `LATCH_RST; // [R19]
         end else begin
            if (soft_exit)
               soft_rst_bit_o <= 1'b0; // [R11]
            else if (soft_rst_wr_i && next_state == S_SOFT)
               soft_rst_bit_o <= 1'b1;
            if (pwr_down_wr_i && mgmt_ready_o)
               pwr_down_bit_o <= pwr_down_val_i;
            if (save_wr_i && mgmt_ready_o)
               save_bits_o <= save_val_i;
            if (pwr_down_bit_o)
               {latching_maximum_status_bit_o, latching_high_status_bit_o,
                latching_low_status_bit_o} <= `LATCH_RST; // [R15]
            else
               {latching_maximum_status_bit_o, latching_high_status_bit_o,
                latching_low_status_bit_o} <=
                  {latching_maximum_status_bit_o, latching_high_status_bit_o,
                   latching_low_status_bit_o} | latch_set_i;
         end
         // Address is captured only on hardware or power-on exit
         if (leave_hw)
            addr_field_o <= port_addr_i; // [R20] [R12]
      end
   end

   // ---------------------------------------------------------------
   // Output gating
   // ---------------------------------------------------------------
   // MAC side stays gated after a reset until both clocks are valid; clearing
   // the power-down bit reopens it at once, before the clocks relock
   wire pd_now = hard_rst || pwr_down_bit_o || !pin_sync;
   wire run    = (next_state == S_RUN) && !pwr_down_bit_o && !por_kick;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         in_reset_o   <= 1'b1;
         mgmt_ready_o <= 1'b0;
         reset_done_o <= 1'b0;
         power_down_o <= 1'b1;
         mac_out_en_o <= 1'b0;
         mac_in_en_o  <= 1'b0;
         line_tx_oe_o <= 1'b0;
         en100_o      <= 1'b0;
         en10_o       <= 1'b0;
      end else begin
         // Exit steps run out of reset, the line drive comes up there
         in_reset_o   <= any_rst; // [R19]
         mgmt_ready_o <= !hard_rst && !por_kick &&
                         (state != S_EXIT || cnt_done); // [R02]
         reset_done_o <= (next_state == S_RUN) && !por_kick; // [R23]
         power_down_o <= pd_now; // [R13] [R10]
         mac_out_en_o <= run; // [R14] [R04]
         mac_in_en_o  <= run; // [R19]
         line_tx_oe_o <= !pd_now && !any_rst; // [R14]
         en100_o <= !pd_now && !(save_bits_o[`EXT2_SAVE100_BIT]
                                 && !speed100_i); // [R17]
         en10_o  <= !pd_now && !(save_bits_o[`EXT2_SAVE10_BIT]
                                 && speed100_i); // [R18]
      end
   end
endmodule

// File: verilog/rst_seq_map.vh
// Constants for the reset and power-down sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef RST_SEQ_MAP_VH
`define RST_SEQ_MAP_VH
// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define EXIT_STEPS_NS      640
`define EXIT_STEPS_REFCLK  16
`define POR_HOLD_NS        20000
`define SOFT_RST_REFCLK    2
`define HW_RST_MIN_REFCLK  5
`define LOCK_TYP_MS        53
// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define CTRL_SOFT_RST_BIT  15
`define CTRL_PWR_DOWN_BIT  11
`define EXT_ADDR_LSB       6
`define EXT_ADDR_MSB       10
`define EXT2_SAVE100_BIT   0
`define EXT2_SAVE10_BIT    1
`define PWR_DOWN_RST       1'b0
`define SAVE_RST           1'b0
`define LATCH_RST          3'h0
`endif

// File: verilog/sync_cnt.v
// Generic down counter that raises done when a loaded count expires.
// Assumes one clock; load wins over counting.
`timescale 1ns/1ns
module sync_cnt #(
   parameter W = 16
) (
   input  wire         clk_i,    // System clock
   input  wire         rst_i,    // Async reset, active high
   input  wire         load_i,   // Load start value
   input  wire [W-1:0] value_i,  // Start value
   output reg          done_o    // Count at zero
);
   reg [W-1:0] count;
   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // Done is registered so it rises the cycle after count hits zero
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count  <= {W{1'b0}};
         done_o <= 1'b0;
      end else if (load_i) begin
         count  <= value_i;
         done_o <= 1'b0;
      end else begin
         if (count != {W{1'b0}})
            count <= count - {{(W-1){1'b0}}, 1'b1};
         done_o <= (count == {W{1'b0}});
      end
   end
endmodule
